//--- verif/prcs_pins_model.sv
// Pins and analog comparator at the far side of the port block
`timescale 1ns/10ps
`default_nettype none
module prcs_pins_model (
  input wire logic core_clk,
  input wire logic [7:0] a_ext,
  input wire logic [5:0] b_ext,
  input var int sig_mv,
  input var int ref_mv,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [5:0] b_out,
  input wire logic [5:0] b_oe,
  input wire logic power_on,
  output logic [7:0] a_pin,
  output logic [5:0] b_pin,
  output logic result
);
  // Driven bit shows the driver, else the outside level; no contention
  assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_out) | (~b_oe & b_ext);
  initial result = 1'b0;
  // Unpowered output wanders, so a missing stop mask shows up
  always @(posedge core_clk)
    if (power_on)
      result <= (sig_mv > ref_mv);
    else
      result <= ~result;
endmodule // prcs_pins_model
`default_nettype wire

//--- verif/prcs_properties.sv
// Checker for the port reset and comparator block
`timescale 1ns/10ps
`default_nettype none
`include "prcs_defines.vh"
module prcs_properties #(
  parameter A_WIDTH = 8,
  parameter B_WIDTH = 6
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr,
  input wire [A_WIDTH-1:0] port_a_pin_oe,
  input wire [B_WIDTH-1:0] port_b_pin_oe,
  input wire comparator_power_on,
  input wire halt_mode,
  input wire stop_mode,
  input wire stop_mode_recovery_event,
  input wire watchdog_timeout_event,
  input wire soft_restart,
  input wire global_reset,
  input wire signal_pin_irq,
  input wire halt_wake
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Single write, so the figure seen two edges later is not overtaken
  sequence dir_b_set;
    reg_wr && reg_addr == `PRCS_ADDR_B_DIR ##1 !(reg_wr && reg_addr == `PRCS_ADDR_B_DIR);
  endsequence
  a_dir_drives_pin: assert property (dir_b_set |=>
    port_b_pin_oe[4:0] == $past(reg_wr_data[4:0], 2)) else $error("direction not on pins");
  a_reset_all_inputs: assert property ($fell(srst) |->
    !(|port_a_pin_oe) && !(|port_b_pin_oe)) else $error("pin driven after reset");
  a_restart_follows: assert property (
    stop_mode_recovery_event || watchdog_timeout_event |=> soft_restart)
    else $error("restart pulse missing");
  a_restart_cause: assert property (soft_restart |->
    $past(stop_mode_recovery_event) || $past(watchdog_timeout_event))
    else $error("restart without event");
  a_stop_powers_off: assert property (stop_mode |=> !comparator_power_on)
    else $error("comparator powered in stop");
  a_wake_in_halt: assert property (halt_wake |-> signal_pin_irq && $past(halt_mode))
    else $error("wake outside halt");
  a_irq_one_cycle: assert property (signal_pin_irq |=> !signal_pin_irq)
    else $error("interrupt pulse too long");
  a_lv_masked_stop: assert property (global_reset |-> !$past(stop_mode))
    else $error("low voltage reset in stop");
endmodule // prcs_properties
bind prcs_top prcs_properties #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH)) i_prcs_properties (
  .core_clk, .srst, .reg_addr, .reg_wr_data, .reg_wr, .port_a_pin_oe, .port_b_pin_oe,
  .comparator_power_on, .halt_mode, .stop_mode, .stop_mode_recovery_event,
  .watchdog_timeout_event, .soft_restart, .global_reset, .signal_pin_irq, .halt_wake);
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the port reset and comparator block
`timescale 1ns/10ps
`default_nettype none
`include "prcs_defines.vh"
module tb;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, halt_mode = 1'b0;
  logic stop_mode = 1'b0, smr_ev = 1'b0, wdt_ev = 1'b0, lv_flag = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, a_ext = 8'h00, reg_rd_data, a_in, a_out, a_oe;
  logic [5:0] b_ext = 6'h00, b_in, b_out, b_oe;
  logic cmp_res, pwr_on, soft_rst, g_rst, irq, wake;
  int sig_mv = 50, ref_mv = 100, errors = 0, check_count = 0, irqs = 0, wakes = 0, cycles = 0;
  prcs_top i_prcs_top (.core_clk, .srst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
    .reg_rd_data, .port_a_pin_in(a_in), .port_a_pin_out(a_out), .port_a_pin_oe(a_oe),
    .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe),
    .comparator_result_in(cmp_res), .comparator_power_on(pwr_on), .halt_mode, .stop_mode,
    .stop_mode_recovery_event(smr_ev), .watchdog_timeout_event(wdt_ev),
    .soft_restart(soft_rst), .low_voltage_trip_point(lv_flag), .global_reset(g_rst),
    .signal_pin_irq(irq), .halt_wake(wake));
  prcs_pins_model i_prcs_pins_model (.core_clk, .a_ext, .b_ext, .sig_mv, .ref_mv, .a_out,
    .a_oe, .b_out, .b_oe, .power_on(pwr_on), .a_pin(a_in), .b_pin(b_in), .result(cmp_res));
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    irqs <= irqs + int'(irq);
    wakes <= wakes + int'(wake);
    if (cycles == 2000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rd_data, exp);
    @(posedge core_clk);
  endtask
  task automatic t_reset;
    a_ext <= 8'hC3;
    wr(`PRCS_ADDR_A_OUT, 8'h5A);
    wr(`PRCS_ADDR_A_DIR, 8'hFF);
    wr(`PRCS_ADDR_A_IN, 8'h33);
    wr(`PRCS_ADDR_B_SFR, 8'h20);
    rd(`PRCS_ADDR_A_IN, 8'h33);
    check(a_oe, 8'hFF);
    srst <= 1'b1;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd(`PRCS_ADDR_A_OUT, 8'h5A);
    rd(`PRCS_ADDR_A_DIR, 8'h00);
    rd(`PRCS_ADDR_B_SFR, 8'h00);
    rd(`PRCS_ADDR_A_IN, 8'hC3);
  endtask
  task automatic t_events;
    wr(`PRCS_ADDR_A_DIR, 8'h0F);
    wr(`PRCS_ADDR_A_SFR, 8'h81);
    smr_ev <= 1'b1;
    @(posedge core_clk);
    smr_ev <= 1'b0;
    wdt_ev <= 1'b1;
    @(posedge core_clk);
    wdt_ev <= 1'b0;
    #1 check(8'(soft_rst), 8'h01);
    rd(`PRCS_ADDR_A_DIR, 8'h0F);
    rd(`PRCS_ADDR_A_SFR, 8'h81);
  endtask
  task automatic t_sync;
    wr(`PRCS_ADDR_A_SFR, 8'h00);
    a_ext <= 8'h30;
    rd(`PRCS_ADDR_A_IN, 8'hC3);
    cyc(3);
    rd(`PRCS_ADDR_A_IN, 8'h33);
    check(a_out, 8'h5A);
    wr(`PRCS_ADDR_A_IN, 8'hFF);
    @(posedge core_clk);
    rd(`PRCS_ADDR_A_IN, 8'h3F);
  endtask
  task automatic t_cmp;
    int n;
    int w;
    wr(`PRCS_ADDR_B_SFR, 8'h00);
    wr(`PRCS_ADDR_B_OUT, 8'h1F);
    wr(`PRCS_ADDR_B_DIR, 8'h21);
    cyc(1);
    check(8'(b_oe), 8'h21);
    check(8'(b_out), 8'h1F);
    wr(`PRCS_ADDR_B_DIR, 8'h00);
    b_ext <= 6'h08;
    wr(`PRCS_ADDR_B_SFR, 8'h18);
    wr(`PRCS_ADDR_CMP_CTRL, 8'h01);
    halt_mode <= 1'b1;
    cyc(4);
    rd(`PRCS_ADDR_CMP_CTRL, 8'h05);
    check(8'(pwr_on), 8'h01);
    n = irqs;
    w = wakes;
    sig_mv <= 150;
    cyc(6);
    check(8'(irqs - n), 8'h01);
    check(8'(wakes - w), 8'h01);
    rd(`PRCS_ADDR_B_IN, 8'h18);
    b_ext <= 6'h18;
    sig_mv <= 50;
    cyc(5);
    rd(`PRCS_ADDR_B_IN, 8'h08);
    check(8'(irqs - n), 8'h01);
    wr(`PRCS_ADDR_CMP_CTRL, 8'h00);
    sig_mv <= 150;
    cyc(6);
    check(8'(irqs - n), 8'h01);
    stop_mode <= 1'b1;
    cyc(5);
    check(8'(pwr_on), 8'h00);
    rd(`PRCS_ADDR_B_IN, 8'h08);
  endtask
  task automatic t_lv;
    lv_flag <= 1'b1;
    cyc(5);
    check(8'(g_rst), 8'h00);
    stop_mode <= 1'b0;
    cyc(2);
    check(8'(g_rst), 8'h01);
    lv_flag <= 1'b0;
    cyc(5);
    check(8'(g_rst), 8'h00);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(`PRCS_ADDR_B_DIR, 8'h00);
    rd(`PRCS_ADDR_A_SFR, 8'h00);
    rd(8'hE0, 8'h00);
    t_reset();
    t_events();
    t_sync();
    t_cmp();
    t_lv();
    results();
  end
endmodule // tb
`default_nettype wire

//--- verilog/prcs_defines.vh
// Register map, field positions and reset values of the port and comparator block
// Overview of operation
// - A full reset leaves both ports' output value registers as they were.
// - A full reset clears both direction registers so every pin becomes an input.
// - During a full reset each input value register loads the current synchronized pin sample.
// - A full reset clears both special-function registers to zero, disabling all special functions.
// - Stop-mode-recovery and watchdog time-out events are not full resets and leave port control alone.
// - Setting special-function bits 3 and 4 of the second port enables the comparator function.
// - With the comparator enabled, input bit 4 holds the synchronized result and bit 3 the reference pin.
// - With the comparator selected, the signal pin's interrupt comes from the comparator result.
// - The result bit is high when signal exceeds reference and low when it is below.
// - The comparator keeps working in HALT, and its enabled interrupt wakes the device from HALT.
// - In STOP the comparator is powered down and gives no result and no interrupt.
// - The low-voltage flag drives a global reset only in RUN and HALT, never in STOP.
// - A direction bit of one makes the pin an output, zero makes it an input.
// - Every input pin passes two synchronizer flip-flops before the input value register.
// - Writes to input-configured bits of the input register are replaced by the next sample.
`ifndef PRCS_DEFINES_VH
`define PRCS_DEFINES_VH
`define PRCS_ADDR_B_SFR 8'hD7
`define PRCS_ADDR_B_DIR 8'hD6
`define PRCS_ADDR_B_OUT 8'hD5
`define PRCS_ADDR_B_IN 8'hD4
`define PRCS_ADDR_A_SFR 8'hD3
`define PRCS_ADDR_A_DIR 8'hD2
`define PRCS_ADDR_A_OUT 8'hD1
`define PRCS_ADDR_A_IN 8'hD0
`define PRCS_ADDR_CMP_CTRL 8'hD8
`define PRCS_DIR_RESET 8'h00
`define PRCS_SFR_RESET 8'h00
`define PRCS_CTRL_RESET 8'h00
`define PRCS_CMP_REF_BIT 3
`define PRCS_CMP_SIG_BIT 4
`define PRCS_OD_ONLY_BIT 5
`define PRCS_CTRL_IRQ_EN_BIT 0
`define PRCS_CTRL_RESULT_BIT 1
`define PRCS_CTRL_SELECTED_BIT 2
`endif

//--- verilog/prcs_sync.v
// Two-stage synchronizer for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module prcs_sync #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  // No reset, so a full reset still sees the live pin sample
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge core_clk)
  begin
    stage1_reg <= async_in;
    stage2_reg <= stage1_reg;
  end

  assign sync_out = stage2_reg;
endmodule // prcs_sync
`default_nettype wire

//--- verilog/prcs_top.v
// Two I/O ports with reset handling and comparator select
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "prcs_defines.vh"
module prcs_top #(
  parameter A_WIDTH = 8,
  parameter B_WIDTH = 6
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rd_data,
  input wire [A_WIDTH-1:0] port_a_pin_in,
  output reg [A_WIDTH-1:0] port_a_pin_out,
  output reg [A_WIDTH-1:0] port_a_pin_oe,
  input wire [B_WIDTH-1:0] port_b_pin_in,
  output reg [B_WIDTH-1:0] port_b_pin_out,
  output reg [B_WIDTH-1:0] port_b_pin_oe,
  input wire comparator_result_in,
  output reg comparator_power_on,
  input wire halt_mode,
  input wire stop_mode,
  input wire stop_mode_recovery_event,
  input wire watchdog_timeout_event,
  output reg soft_restart,
  input wire low_voltage_trip_point,
  output reg global_reset,
  output reg signal_pin_irq,
  output reg halt_wake
);

  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Input register next value: sampled for inputs, written or held for outputs
  function [7:0] in_next;
    input [7:0] cur;
    input [7:0] smp;
    input [7:0] dir;
    input [7:0] wdata;
    input wr;
    integer i;
    begin
      in_next = 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (!dir[i])
          in_next[i] = smp[i];
        else if (wr)
          in_next[i] = wdata[i];
        else
          in_next[i] = cur[i];
      end
    end
  endfunction

  wire [A_WIDTH-1:0] a_sync;
  wire [B_WIDTH-1:0] b_sync;
  wire [1:0] analog_sync;

  prcs_sync #(
    .WIDTH(A_WIDTH)
  ) u_sync_a (
    .core_clk(core_clk),
    .async_in(port_a_pin_in),
    .sync_out(a_sync)
  );

  prcs_sync #(
    .WIDTH(B_WIDTH)
  ) u_sync_b (
    .core_clk(core_clk),
    .async_in(port_b_pin_in),
    .sync_out(b_sync)
  );

  prcs_sync #(
    .WIDTH(2)
  ) u_sync_analog (
    .core_clk(core_clk),
    .async_in({low_voltage_trip_point, comparator_result_in}),
    .sync_out(analog_sync)
  );

  reg [A_WIDTH-1:0] a_in_reg;
  reg [A_WIDTH-1:0] a_out_reg;
  reg [A_WIDTH-1:0] a_dir_reg;
  reg [A_WIDTH-1:0] a_sfr_reg;
  reg [B_WIDTH-1:0] b_in_reg;
  reg [B_WIDTH-1:0] b_out_reg;
  reg [B_WIDTH-1:0] b_dir_reg;
  reg [B_WIDTH-1:0] special_function_register;
  reg irq_enable_reg;
  reg irq_src_reg;

  wire wr_a_in = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_A_IN);
  wire wr_a_out = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_A_OUT);
  wire wr_a_dir = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_A_DIR);
  wire wr_a_sfr = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_A_SFR);
  wire wr_b_in = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_B_IN);
  wire wr_b_out = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_B_OUT);
  wire wr_b_dir = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_B_DIR);
  wire wr_b_sfr = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_B_SFR);
  wire wr_ctrl = reg_wr && addr_hit(reg_addr, `PRCS_ADDR_CMP_CTRL);

  // Both select bits needed, a half-set pair leaves plain I/O
  wire comp_selected = special_function_register[`PRCS_CMP_REF_BIT] &&
    special_function_register[`PRCS_CMP_SIG_BIT];
  // High means signal above reference; forced low in STOP (stop_mode)
  wire comp_result = analog_sync[0] && !stop_mode;

  // Pin sample for port B with the comparator rerouted onto bit 4
  reg [B_WIDTH-1:0] b_sample;
  always @*
  begin
    b_sample = b_sync;
    if (comp_selected)
      b_sample[`PRCS_CMP_SIG_BIT] = comp_result;
  end

  wire [7:0] a_in_calc = in_next({{(8-A_WIDTH){1'b0}}, a_in_reg},
    {{(8-A_WIDTH){1'b0}}, a_sync}, {{(8-A_WIDTH){1'b0}}, a_dir_reg},
    reg_wr_data, wr_a_in);
  wire [7:0] b_in_calc = in_next({{(8-B_WIDTH){1'b0}}, b_in_reg},
    {{(8-B_WIDTH){1'b0}}, b_sample}, {{(8-B_WIDTH){1'b0}}, b_dir_reg},
    reg_wr_data, wr_b_in);

  // Interrupt source for the signal pin
  wire irq_src_next = comp_selected ? comp_result : b_sync[`PRCS_CMP_SIG_BIT];
  wire irq_edge = irq_src_next && !irq_src_reg && irq_enable_reg;

  // Output registers are never reset, so their contents survive a full reset
  always @(posedge core_clk)
  begin
    if (wr_a_out)
      a_out_reg <= reg_wr_data[A_WIDTH-1:0];
    if (wr_b_out)
      b_out_reg <= reg_wr_data[B_WIDTH-1:0];
  end

  // Input registers follow the sample even through reset
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      a_in_reg <= a_sync;
      b_in_reg <= b_sample;
    end
    else
    begin
      a_in_reg <= a_in_calc[A_WIDTH-1:0];
      b_in_reg <= b_in_calc[B_WIDTH-1:0];
    end
  end

  // Only srst clears control; recovery and watchdog events never touch it
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      a_dir_reg <= `PRCS_DIR_RESET;
      b_dir_reg <= 6'h00;
      a_sfr_reg <= `PRCS_SFR_RESET;
      special_function_register <= 6'h00;
      irq_enable_reg <= 1'b0;
      irq_src_reg <= 1'b0;
    end
    else
    begin
      if (wr_a_dir)
        a_dir_reg <= reg_wr_data[A_WIDTH-1:0];
      if (wr_b_dir)
        b_dir_reg <= reg_wr_data[B_WIDTH-1:0];
      if (wr_a_sfr)
        a_sfr_reg <= reg_wr_data[A_WIDTH-1:0];
      if (wr_b_sfr)
        special_function_register <= reg_wr_data[B_WIDTH-1:0];
      if (wr_ctrl)
        irq_enable_reg <= reg_wr_data[`PRCS_CTRL_IRQ_EN_BIT];
      irq_src_reg <= irq_src_next;
    end
  end

  // Pin drivers; port A open-drain per bit, port B bit 5 open-drain only
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      port_a_pin_out <= {A_WIDTH{1'b0}};
      port_a_pin_oe <= {A_WIDTH{1'b0}};
      port_b_pin_out <= {B_WIDTH{1'b0}};
      port_b_pin_oe <= {B_WIDTH{1'b0}};
    end
    else
    begin
      port_a_pin_out <= a_out_reg;
      port_a_pin_oe <= a_dir_reg & (~a_sfr_reg | ~a_out_reg);
      port_b_pin_out <= b_out_reg;
      port_b_pin_oe <= b_dir_reg;
      port_b_pin_oe[`PRCS_OD_ONLY_BIT] <= b_dir_reg[`PRCS_OD_ONLY_BIT] &&
        !b_out_reg[`PRCS_OD_ONLY_BIT];
    end
  end

  // Comparator power, interrupt, wake and restart request
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      comparator_power_on <= 1'b0;
      signal_pin_irq <= 1'b0;
      halt_wake <= 1'b0;
      soft_restart <= 1'b0;
    end
    else
    begin
      comparator_power_on <= comp_selected && !stop_mode;
      signal_pin_irq <= irq_edge && !(comp_selected && stop_mode);
      halt_wake <= irq_edge && comp_selected && halt_mode && !stop_mode;
      // Restart request leaves every port register untouched
      soft_restart <= stop_mode_recovery_event || watchdog_timeout_event;
    end
  end

  // Not cleared by srst: it is the source of the reset, not a victim of it
  always @(posedge core_clk)
  begin
    global_reset <= analog_sync[1] && !stop_mode;
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      `PRCS_ADDR_A_IN: rd_mux[A_WIDTH-1:0] = a_in_reg;
      `PRCS_ADDR_A_OUT: rd_mux[A_WIDTH-1:0] = a_out_reg;
      `PRCS_ADDR_A_DIR: rd_mux[A_WIDTH-1:0] = a_dir_reg;
      `PRCS_ADDR_A_SFR: rd_mux[A_WIDTH-1:0] = a_sfr_reg;
      `PRCS_ADDR_B_IN: rd_mux[B_WIDTH-1:0] = b_in_reg;
      `PRCS_ADDR_B_OUT: rd_mux[B_WIDTH-1:0] = b_out_reg;
      `PRCS_ADDR_B_DIR: rd_mux[B_WIDTH-1:0] = b_dir_reg;
      `PRCS_ADDR_B_SFR: rd_mux[B_WIDTH-1:0] = special_function_register;
      `PRCS_ADDR_CMP_CTRL:
      begin
        rd_mux[`PRCS_CTRL_IRQ_EN_BIT] = irq_enable_reg;
        rd_mux[`PRCS_CTRL_RESULT_BIT] = comp_result;
        rd_mux[`PRCS_CTRL_SELECTED_BIT] = comp_selected;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (srst)
      reg_rd_data <= 8'h00;
    else if (reg_rd)
      reg_rd_data <= rd_mux;
    else
      reg_rd_data <= 8'h00;
  end

endmodule // prcs_top
`default_nettype wire
